// ===== rtl/dur_pkg.sv
// Package of constants for the dual image upgrade read-back block.
// Assumes a word-indexed register port with offsets 0..7.
package dur_pkg;
  localparam logic [2:0] ADDR_TRIGGER = 3'h0;
  localparam logic [2:0] ADDR_IMAGE_LOAD = 3'h1;
  localparam logic [2:0] ADDR_FETCH = 3'h2;
  localparam logic [2:0] ADDR_BUSY = 3'h3;
  localparam logic [2:0] ADDR_WATCHDOG_READBACK = 3'h4;
  localparam logic [2:0] ADDR_PRIOR_STATE_ONE = 3'h5;
  localparam logic [2:0] ADDR_PRIOR_STATE_TWO = 3'h6;
  localparam logic [2:0] ADDR_IMAGE_SELECT_READBACK = 3'h7;
  // Offset 0 fields
  localparam int TRIG_RECONFIG_BIT = 0;
  localparam int TRIG_WD_RESTART_BIT = 1;
  // Offset 2 fields
  localparam int FETCH_WD_BIT = 0;
  localparam int FETCH_PRIOR_TWO_BIT = 1;
  localparam int FETCH_PRIOR_ONE_BIT = 2;
  localparam int FETCH_IMAGE_BIT = 3;
  localparam int FETCH_COUNT = 4;
  // Offset 4 layout
  localparam int WD_VALUE_LSB = 0;
  localparam int WD_VALUE_W = 12;
  localparam int WD_FULL_W = 29;
  localparam int WD_STATE_BIT = 12;
  localparam int WD_MSM_LSB = 13;
  localparam int MSM_W = 4;
  // Offsets 5 and 6 layout
  localparam int PS_SRC_LSB = 0;
  localparam int PS_MSM_LSB = 4;
  // Offset 7 layout
  localparam int IMG_OVR_BIT = 0;
  localparam int IMG_SEL_BIT = 1;
  // Timing
  localparam int CLK_MHZ = 125;
  localparam int STROBE_NS = 250;
  localparam int STROBE_CYCLES = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int XFER_CYCLES = 8;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_XFER = 3'b010,
    ST_DONE = 3'b100
  } dur_state_t;
endpackage

// ===== rtl/dur_if.sv
// Interface carrying the strobe timer's request and state.
// Assumes both ends share mclk_i.
interface dur_strobe_if;
  logic fire;
  logic active;
  modport ctrl (output fire, input active);
  modport timer (input fire, output active);
endinterface

// ===== rtl/dur_strobe.sv
// Pulse stretcher holding an active-high strobe for a fixed cycle count.
// Assumes a synchronous active-high reset and a shared clock enable.
module dur_strobe
  import dur_pkg::*;
#(
  parameter int CYCLES = STROBE_CYCLES
)
(
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  dur_strobe_if.timer port
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;

  // Load on fire, count down otherwise
  always_comb
  begin
    nxt_cnt = cnt_ff;
    if (port.fire)
    begin
      nxt_cnt = CW'(CYCLES);
    end
    else if (cnt_ff != '0)
    begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      cnt_ff <= '0;
    end
    else if (ce_i)
    begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign port.active = (cnt_ff != '0);
endmodule

// ===== rtl/dur_readback.sv
// Register port, busy handling and read-back of the upgrade block status.
// Assumes upgrade block status words are presented on plain inputs and
// sampled while an exchange runs; the upgrade clock is made here.
module dur_readback
  import dur_pkg::*;
#(
  parameter int XFER_LEN = XFER_CYCLES
)
(
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [2:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] rdata_o,
  output logic busy_o,
  input wire logic [WD_FULL_W-1:0] wd_count_i,
  input wire logic wd_state_i,
  input wire logic [MSM_W-1:0] msm_cur_i,
  input wire logic [3:0] ps1_src_i,
  input wire logic [MSM_W-1:0] ps1_msm_i,
  input wire logic [3:0] ps2_src_i,
  input wire logic [MSM_W-1:0] ps2_msm_i,
  output logic upgrade_block_clock_o,
  output logic watchdog_restart_n_o,
  output logic reconfig_request_n_o,
  output logic image_ovr_o,
  output logic image_sel_o
);
  localparam int XW = $clog2(XFER_LEN + 1);

  dur_state_t state_ff, nxt_state;
  logic [XW-1:0] xcnt_ff, nxt_xcnt;
  logic [FETCH_COUNT-1:0] pend_ff, nxt_pend;
  logic [16:0] wd_ff, nxt_wd;
  logic [7:0] ps1_ff, nxt_ps1;
  logic [7:0] ps2_ff, nxt_ps2;
  logic img_ovr_ff, nxt_img_ovr;
  logic img_sel_ff, nxt_img_sel;
  // Offset 7 copy, refreshed only by an input-register fetch
  logic [1:0] imgrb_ff, nxt_imgrb;
  logic [31:0] rdata_ff, nxt_rdata;
  logic clkdiv_ff;
  logic wr_ok;
  dur_strobe_if rst_if ();
  dur_strobe_if cfg_if ();

  // Decode one address for a write
  function automatic logic hit(input logic [2:0] a, input logic [2:0] want);
    return a == want;
  endfunction

  // Register writes are refused while an exchange is running
  assign wr_ok = ce_i & wr_i & (state_ff == ST_IDLE);

  // Restart bypasses busy gating on purpose
  assign rst_if.fire = ce_i & wr_i & hit(addr_i, ADDR_TRIGGER)
    & wdata_i[TRIG_WD_RESTART_BIT];
  assign cfg_if.fire = wr_ok & hit(addr_i, ADDR_TRIGGER)
    & wdata_i[TRIG_RECONFIG_BIT];

  // Strobe timers sized from the clock rate
  dur_strobe #(.CYCLES(STROBE_CYCLES)) u_rst_strobe
  (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .port(rst_if.timer)
  );
  dur_strobe #(.CYCLES(STROBE_CYCLES)) u_cfg_strobe
  (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .port(cfg_if.timer)
  );

  // Exchange sequencer and captured read-back values
  always_comb
  begin
    nxt_state = state_ff;
    nxt_xcnt = xcnt_ff;
    nxt_pend = pend_ff;
    nxt_wd = wd_ff;
    nxt_ps1 = ps1_ff;
    nxt_ps2 = ps2_ff;
    nxt_img_ovr = img_ovr_ff;
    nxt_img_sel = img_sel_ff;
    nxt_imgrb = imgrb_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (wr_ok && hit(addr_i, ADDR_FETCH)
          && wdata_i[FETCH_COUNT-1:0] != '0)
        begin
          nxt_pend = wdata_i[FETCH_COUNT-1:0];
          nxt_xcnt = XW'(XFER_LEN);
          nxt_state = ST_XFER;
        end
        else if (wr_ok && hit(addr_i, ADDR_IMAGE_LOAD))
        begin
          // Image choice is latched here, not taken from the pin
          nxt_img_ovr = wdata_i[IMG_OVR_BIT];
          nxt_img_sel = wdata_i[IMG_SEL_BIT];
          nxt_pend = '0;
          nxt_xcnt = XW'(XFER_LEN);
          nxt_state = ST_XFER;
        end
      end
      ST_XFER:
      begin
        if (xcnt_ff > XW'(1))
        begin
          nxt_xcnt = xcnt_ff - 1'b1;
        end
        else
        begin
          nxt_xcnt = '0;
          nxt_state = ST_DONE;
        end
      end
      ST_DONE:
      begin
        // Values change only when a fetch completes
        if (pend_ff[FETCH_WD_BIT])
        begin
          nxt_wd = {msm_cur_i, wd_state_i,
            wd_count_i[WD_FULL_W-1 -: WD_VALUE_W]};
        end
        if (pend_ff[FETCH_PRIOR_ONE_BIT])
        begin
          nxt_ps1 = {ps1_msm_i, ps1_src_i};
        end
        if (pend_ff[FETCH_PRIOR_TWO_BIT])
        begin
          nxt_ps2 = {ps2_msm_i, ps2_src_i};
        end
        if (pend_ff[FETCH_IMAGE_BIT])
        begin
          nxt_imgrb[IMG_OVR_BIT] = img_ovr_ff;
          nxt_imgrb[IMG_SEL_BIT] = img_sel_ff;
        end
        nxt_pend = '0;
        nxt_state = ST_IDLE;
      end
      default:
      begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      state_ff <= ST_IDLE;
      xcnt_ff <= '0;
      pend_ff <= '0;
      wd_ff <= '0;
      ps1_ff <= '0;
      ps2_ff <= '0;
      img_ovr_ff <= 1'b0;
      img_sel_ff <= 1'b0;
      imgrb_ff <= '0;
    end
    else if (ce_i)
    begin
      state_ff <= nxt_state;
      xcnt_ff <= nxt_xcnt;
      pend_ff <= nxt_pend;
      wd_ff <= nxt_wd;
      ps1_ff <= nxt_ps1;
      ps2_ff <= nxt_ps2;
      img_ovr_ff <= nxt_img_ovr;
      img_sel_ff <= nxt_img_sel;
      imgrb_ff <= nxt_imgrb;
    end
  end

  // Read mux, served any time without waiting on busy
  always_comb
  begin
    nxt_rdata = rdata_ff;
    if (ce_i && rd_i)
    begin
      nxt_rdata = ZERO_WORD;
      case (addr_i)
        ADDR_BUSY: nxt_rdata[0] = (state_ff != ST_IDLE);
        ADDR_WATCHDOG_READBACK:
        begin
          nxt_rdata[16:0] = wd_ff;
        end
        ADDR_PRIOR_STATE_ONE: nxt_rdata[7:0] = ps1_ff;
        ADDR_PRIOR_STATE_TWO: nxt_rdata[7:0] = ps2_ff;
        ADDR_IMAGE_SELECT_READBACK:
        begin
          nxt_rdata[IMG_OVR_BIT] = imgrb_ff[IMG_OVR_BIT];
          nxt_rdata[IMG_SEL_BIT] = imgrb_ff[IMG_SEL_BIT];
        end
        default: nxt_rdata = ZERO_WORD;
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      rdata_ff <= ZERO_WORD;
      clkdiv_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      rdata_ff <= nxt_rdata;
      clkdiv_ff <= ~clkdiv_ff;
    end
  end

  // Busy straight from the sequencer, so it rises with the write edge
  assign busy_o = (state_ff != ST_IDLE);
  assign rdata_o = rdata_ff;
  assign upgrade_block_clock_o = clkdiv_ff;
  assign watchdog_restart_n_o = ~rst_if.active;
  assign reconfig_request_n_o = ~cfg_if.active;
  assign image_ovr_o = img_ovr_ff;
  assign image_sel_o = img_sel_ff;
endmodule

// ===== dv/dur_readback_assertions.sv
// Checker for the upgrade read-back register port and strobes.
// Assumes binding onto dur_readback, one clock, sync reset.
module dur_readback_assertions
  import dur_pkg::*;
(
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [2:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] wdata_i,
  input wire logic [31:0] rdata_o,
  input wire logic busy_o,
  input wire logic upgrade_block_clock_o,
  input wire logic watchdog_restart_n_o,
  input wire logic reconfig_request_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);
  // Requests under clock enable, busy or not; a frozen clock enable takes nothing
  wire logic w_go = ce_i && wr_i;
  wire logic r_go = ce_i && rd_i;
  property p_fetch;
    w_go && !busy_o && addr_i == ADDR_FETCH && |wdata_i[3:0] |=> busy_o;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch no busy");
  property p_hold;
    $rose(busy_o) |-> busy_o[*8];
  endproperty
  a_hold: assert property (p_hold) else $error("busy short");
  property p_restart;
    w_go && addr_i == ADDR_TRIGGER && wdata_i[1] |=> !watchdog_restart_n_o;
  endproperty
  a_restart: assert property (p_restart) else $error("no pulse");
  property p_strobe;
    $fell(watchdog_restart_n_o) |-> !watchdog_restart_n_o[*8];
  endproperty
  a_strobe: assert property (p_strobe) else $error("too short");
  property p_clk;
    ce_i |=> upgrade_block_clock_o != $past(upgrade_block_clock_o);
  endproperty
  a_clk: assert property (p_clk) else $error("no toggle");
  property p_recfg;
    w_go && busy_o && addr_i == ADDR_TRIGGER && reconfig_request_n_o
      |=> reconfig_request_n_o;
  endproperty
  a_recfg: assert property (p_recfg) else $error("busy no gate");
  // A low clock enable must leave busy and the divided clock alone
  property p_freeze;
    !ce_i |=> $stable(busy_o) && $stable(upgrade_block_clock_o);
  endproperty
  a_freeze: assert property (p_freeze) else $error("not frozen");
  property p_rsv4;
    r_go && addr_i == ADDR_WATCHDOG_READBACK |=> rdata_o[31:17] == 15'h0;
  endproperty
  a_rsv4: assert property (p_rsv4) else $error("reserved set");
  property p_rsv7;
    r_go && addr_i == ADDR_IMAGE_SELECT_READBACK |=> rdata_o[31:2] == 30'h0;
  endproperty
  a_rsv7: assert property (p_rsv7) else $error("reserved set");
  c_fetch: cover property (w_go && addr_i == ADDR_FETCH);
  c_restart: cover property ($fell(watchdog_restart_n_o));
  c_done: cover property ($fell(busy_o));
endmodule
bind dur_readback dur_readback_assertions u_chk (.mclk_i, .sys_rst_i,
  .ce_i, .addr_i, .wr_i, .rd_i, .wdata_i, .rdata_o, .busy_o,
  .upgrade_block_clock_o, .watchdog_restart_n_o, .reconfig_request_n_o);

// ===== dv/dur_far_model.sv
// Far-side model of the upgrade hardware status words.
// Assumes pat_i stays steady while an exchange samples it.
module dur_far_model
(
  input wire logic pat_i,
  output logic [28:0] wd_count_o,
  output logic wd_state_o,
  output logic [3:0] msm_cur_o,
  output logic [15:0] prior_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Two distinct sets, so a held capture differs from a fresh one
  assign wd_count_o = pat_i ? 29'h0543_2100 : 29'h1ABC_DEF5;
  assign wd_state_o = pat_i;
  assign msm_cur_o = pat_i ? 4'h9 : 4'h6;
  assign prior_o = pat_i ? 16'h1E5C : 16'h72A3;
endmodule

// ===== dv/dual_image_upgrade_readback_test.sv
// Self-checking bench for the upgrade read-back register port.
// Assumes dur_far_model feeds the status inputs.
`define CHK(g, e) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("mismatch t=%0t got %h exp %h", $time, g, e); \
    end \
  end
module dual_image_upgrade_readback_test;
  timeunit 1ns;
  timeprecision 1ps;
  import dur_pkg::*;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic [2:0] addr_i = 3'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] wdata_i = 32'h0;
  logic pat = 1'b0;
  logic [1:0] img = 2'h0;
  logic [31:0] e;
  logic [31:0] rdata_o;
  logic busy_o, upgrade_block_clock_o, image_ovr_o, image_sel_o;
  logic watchdog_restart_n_o, reconfig_request_n_o;
  wire logic [28:0] wd_count_i;
  wire logic wd_state_i;
  wire logic [3:0] msm_cur_i, ps1_src_i, ps1_msm_i, ps2_src_i, ps2_msm_i;
  logic [2:0] offs [4] = '{3'h4, 3'h6, 3'h5, 3'h7};
  int error_cnt = 0;
  int checks_done = 0;
  int n;
  dur_readback dur_readback_inst (.mclk_i, .sys_rst_i, .ce_i, .addr_i,
    .wr_i, .rd_i, .wdata_i, .rdata_o, .busy_o, .wd_count_i, .wd_state_i,
    .msm_cur_i, .ps1_src_i, .ps1_msm_i, .ps2_src_i, .ps2_msm_i,
    .upgrade_block_clock_o, .watchdog_restart_n_o, .reconfig_request_n_o,
    .image_ovr_o, .image_sel_o);
  dur_far_model dur_far_model_inst (.pat_i(pat), .wd_count_o(wd_count_i),
    .wd_state_o(wd_state_i), .msm_cur_o(msm_cur_i),
    .prior_o({ps2_msm_i, ps2_src_i, ps1_msm_i, ps1_src_i}));
  // Free-running 125 MHz clock
  always #4 mclk_i = ~mclk_i;
  // Expected word per fetch bit, built from the far-side levels, or from img for the image bit
  function automatic logic [31:0] expv(input int k);
    case (k)
      0: expv = {15'h0, msm_cur_i, wd_state_i, wd_count_i[28:17]};
      1: expv = {24'h0, ps2_msm_i, ps2_src_i};
      2: expv = {24'h0, ps1_msm_i, ps1_src_i};
      default: expv = {30'h0, img};
    endcase
  endfunction
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
  endtask
  // Bounded busy poll, as a master would do after each trigger
  task automatic poll;
    n = 0;
    do
    begin
      rd(ADDR_BUSY);
      n++;
    end
    while (rdata_o[0] !== 1'b0 && n < 20);
    `CHK(rdata_o[0], 1'b0)
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    for (int k = 0; k < 8; k++)
    begin
      rd(k[2:0]);
      `CHK(rdata_o, 32'h0)
    end
    for (int k = 0; k < 4; k++)
    begin
      wr(ADDR_FETCH, 32'h1 << k);
      `CHK(busy_o, 1'b1)
      poll();
      rd(offs[k]);
      `CHK(rdata_o, expv(k))
    end
    // Writes landing while busy: only the restart may act
    wr(ADDR_FETCH, 32'h8);
    wr(ADDR_IMAGE_LOAD, 32'h3);
    wr(ADDR_TRIGGER, 32'h3);
    `CHK(reconfig_request_n_o, 1'b1)
    `CHK(watchdog_restart_n_o, 1'b0)
    poll();
    rd(ADDR_IMAGE_SELECT_READBACK);
    `CHK(rdata_o, 32'h0)
    for (int k = 1; k < 3; k++)
    begin
      img = k[1:0];
      wr(ADDR_IMAGE_LOAD, {30'h0, img});
      poll();
      rd(ADDR_IMAGE_SELECT_READBACK);
      `CHK(rdata_o, {30'h0, img - 2'h1})
      wr(ADDR_FETCH, 32'h8);
      poll();
      rd(ADDR_IMAGE_SELECT_READBACK);
      `CHK(rdata_o, expv(3))
      `CHK({image_sel_o, image_ovr_o}, img)
    end
    // Far side changes; stored word must not follow until refetched
    e = expv(0);
    pat <= 1'b1;
    rd(ADDR_WATCHDOG_READBACK);
    `CHK(rdata_o, e)
    wr(ADDR_FETCH, 32'h1);
    poll();
    rd(ADDR_WATCHDOG_READBACK);
    `CHK(rdata_o, expv(0))
    // Clock enable low parks an exchange part way through
    wr(ADDR_FETCH, 32'h2);
    @(posedge mclk_i);
    ce_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    e[0] = upgrade_block_clock_o;
    repeat (20) @(posedge mclk_i);
    #1;
    `CHK(busy_o, 1'b1)
    `CHK(upgrade_block_clock_o, e[0])
    @(posedge mclk_i);
    ce_i <= 1'b1;
    poll();
    wr(ADDR_TRIGGER, 32'h1);
    n = 0;
    while (reconfig_request_n_o === 1'b0 && n < 100)
    begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    `CHK(n, STROBE_CYCLES)
    conclude();
  end
  // Hang guard, well past the few hundred cycles the tests need
  initial
  begin
    repeat (4000) @(posedge mclk_i);
    error_cnt++;
    conclude();
  end
endmodule
